// file: src/fmh_host.v
// Host sequencer driving the asynchronous SRAM-style pins of the nonvolatile memory
// Notes on behaviour
// RQ1: Device decodes sleep, standby, read, precharge and page read from pins.
// RQ2: Device latches write data when chip-select or write-strobe first rises.
// RQ3: Strobe-controlled write starts as read, becomes write on strobe fall.
// RQ4: Host holds column bits steady at least 15 ns per page column.
// RQ5: Device drives only selected byte lanes on reads with output-gate low.
// RQ6: Device writes only selected byte lanes, masking deselected ones.
// RQ7: Outputs disabled when strobe and output-gate high, or both lanes deselected.
// RQ8: Host may tie lane selects low only without byte writes.
// RQ9: Host waits at least 1 ms after power-up before first access.
// RQ10: Device floats data lines within 20 ns of sleep request.
// RQ11: Device ignores chip-select once sleep request goes low.
// RQ12: Host may request sleep immediately after the last write.
// RQ13: Host waits 450 us after waking before the first access.
// RQ14: Every wait converts to clock cycles, rounded up, before advancing.
`timescale 1ns/1ps
`include "fmh_defines.vh"
module fmh_host #(
    parameter PU_CYC = `FMH_CYC(`FMH_PU_NS),
    parameter WAKE_CYC = `FMH_CYC(`FMH_WAKE_NS)
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // User request side
    input wire req_valid,
    output wire req_ready,
    input wire req_write,
    input wire [`FMH_ADDR_W-1:0] req_addr,
    input wire [`FMH_DATA_W-1:0] req_wdata,
    input wire [1:0] req_lane_n,
    input wire sleep_cmd,
    output reg rsp_valid_ff,
    output reg [`FMH_DATA_W-1:0] rsp_rdata_ff,
    output reg asleep_ff,
    // Memory pins
    output reg chip_select_n_ff,
    output reg write_strobe_n_ff,
    output reg output_gate_n_ff,
    output reg upper_lane_select_n_ff,
    output reg lower_lane_select_n_ff,
    output reg sleep_request_n_ff,
    output reg [`FMH_ADDR_W-1:0] addr_ff,
    input wire [`FMH_DATA_W-1:0] data_lines_in,
    output reg [`FMH_DATA_W-1:0] data_lines_out_ff,
    output reg data_lines_oe_ff
);

// ----------------------------------------
// States and counts
// ----------------------------------------
localparam [6:0] ST_PWRUP = 7'h01;
localparam [6:0] ST_IDLE = 7'h02;
localparam [6:0] ST_READ = 7'h04;
localparam [6:0] ST_WADR = 7'h08;
localparam [6:0] ST_WSTR = 7'h10;
localparam [6:0] ST_PCHG = 7'h20;
localparam [6:0] ST_SLEEP = 7'h40;
// Wait lengths in whole clock cycles, rounded up
localparam integer ACC_N = `FMH_CYC(`FMH_ACC_NS);
localparam integer WP_N = `FMH_CYC(`FMH_WP_NS);
localparam integer PC_N = `FMH_CYC(`FMH_PC_NS);
localparam integer SLP_MIN_N = `FMH_CYC(`FMH_SLP_MIN_NS);
localparam integer PU_N = PU_CYC;
localparam integer WAKE_N = WAKE_CYC;
// Counter-width copies; the longest wait fits the counter
localparam [`FMH_CNT_W-1:0] ACC_CYC = ACC_N[`FMH_CNT_W-1:0];
localparam [`FMH_CNT_W-1:0] WP_CYC = WP_N[`FMH_CNT_W-1:0];
localparam [`FMH_CNT_W-1:0] PC_CYC = PC_N[`FMH_CNT_W-1:0];
localparam [`FMH_CNT_W-1:0] SLP_MIN_CYC = SLP_MIN_N[`FMH_CNT_W-1:0];
localparam [`FMH_CNT_W-1:0] PU_W = PU_N[`FMH_CNT_W-1:0];
localparam [`FMH_CNT_W-1:0] WAKE_W = WAKE_N[`FMH_CNT_W-1:0];

// Sequencer state, shared wait counter, wake phase flag
reg [6:0] state_ff;
reg [`FMH_CNT_W-1:0] cnt_ff;
reg wake_ff;

// Ready only when idle, pins settled
assign req_ready = (state_ff == ST_IDLE) && !sleep_cmd;

// ----------------------------------------
// Sequencer
// ----------------------------------------
// Every pin comes from a flop, so no glitch reaches the memory
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        // All strobes inactive and the data bus released
        state_ff <= ST_PWRUP;
        cnt_ff <= {`FMH_CNT_W{1'b0}};
        wake_ff <= 1'b0;
        rsp_valid_ff <= 1'b0;
        rsp_rdata_ff <= {`FMH_DATA_W{1'b0}};
        asleep_ff <= 1'b0;
        chip_select_n_ff <= 1'b1;
        write_strobe_n_ff <= 1'b1;
        output_gate_n_ff <= 1'b1;
        upper_lane_select_n_ff <= 1'b1;
        lower_lane_select_n_ff <= 1'b1;
        sleep_request_n_ff <= 1'b1;
        addr_ff <= {`FMH_ADDR_W{1'b0}};
        data_lines_out_ff <= {`FMH_DATA_W{1'b0}};
        data_lines_oe_ff <= 1'b0;
    end else begin
        // Response is a one-cycle pulse by default
        rsp_valid_ff <= 1'b0;
        case (state_ff)
            // RQ9: power-up wait
            ST_PWRUP: begin
                // Every pin held inactive until the wait ends
                if (cnt_ff >= PU_W - `FMH_CNT_ONE) begin
                    state_ff <= ST_IDLE;
                    cnt_ff <= {`FMH_CNT_W{1'b0}};
                end else begin
                    cnt_ff <= cnt_ff + `FMH_CNT_ONE;
                end
            end
            ST_IDLE: begin
                // Sleep has priority over a waiting request
                if (sleep_cmd) begin
                    // RQ12: sleep right after a write's precharge
                    sleep_request_n_ff <= 1'b0;
                    asleep_ff <= 1'b1;
                    cnt_ff <= {`FMH_CNT_W{1'b0}};
                    wake_ff <= 1'b0;
                    state_ff <= ST_SLEEP;
                end else if (req_valid) begin
                    // Address, lanes and data latched at take, held to the end
                    // RQ8: lane selects driven from request at each take
                    addr_ff <= req_addr;
                    upper_lane_select_n_ff <= req_lane_n[1];
                    lower_lane_select_n_ff <= req_lane_n[0];
                    chip_select_n_ff <= 1'b0;
                    cnt_ff <= {`FMH_CNT_W{1'b0}};
                    if (req_write) begin
                        data_lines_out_ff <= req_wdata;
                        state_ff <= ST_WADR;
                    end else begin
                        output_gate_n_ff <= 1'b0;
                        state_ff <= ST_READ;
                    end
                end
            end
            // RQ4: address and columns held whole access
            ST_READ: begin
                // Sample data on the last access cycle, then release strobes
                if (cnt_ff >= ACC_CYC - `FMH_CNT_ONE) begin
                    rsp_rdata_ff <= data_lines_in;
                    rsp_valid_ff <= 1'b1;
                    chip_select_n_ff <= 1'b1;
                    output_gate_n_ff <= 1'b1;
                    cnt_ff <= {`FMH_CNT_W{1'b0}};
                    state_ff <= ST_PCHG;
                end else begin
                    cnt_ff <= cnt_ff + `FMH_CNT_ONE;
                end
            end
            // RQ3: write begins as read, strobe falls next
            ST_WADR: begin
                // Bus driven with the strobe fall; outputs already off
                write_strobe_n_ff <= 1'b0;
                data_lines_oe_ff <= 1'b1;
                state_ff <= ST_WSTR;
            end
            // RQ2: strobes rise together, data still held
            ST_WSTR: begin
                // Stretch for access time and strobe width, whichever is longer
                if (cnt_ff >= ACC_CYC - `FMH_CNT_ONE && cnt_ff >= WP_CYC - `FMH_CNT_ONE) begin
                    write_strobe_n_ff <= 1'b1;
                    chip_select_n_ff <= 1'b1;
                    rsp_valid_ff <= 1'b1;
                    cnt_ff <= {`FMH_CNT_W{1'b0}};
                    state_ff <= ST_PCHG;
                end else begin
                    cnt_ff <= cnt_ff + `FMH_CNT_ONE;
                end
            end
            // Precharge after chip-select rise
            ST_PCHG: begin
                // Bus released one cycle after the strobes rise
                data_lines_oe_ff <= 1'b0;
                upper_lane_select_n_ff <= 1'b1;
                lower_lane_select_n_ff <= 1'b1;
                if (cnt_ff >= PC_CYC - `FMH_CNT_ONE) begin
                    cnt_ff <= {`FMH_CNT_W{1'b0}};
                    state_ff <= ST_IDLE;
                end else begin
                    cnt_ff <= cnt_ff + `FMH_CNT_ONE;
                end
            end
            // RQ13: minimum low time, then wake wait
            ST_SLEEP: begin
                // Chip-select stays high; the device ignores it while asleep
                if (!wake_ff) begin
                    // Wake only after the minimum low time and a released command
                    if (cnt_ff >= SLP_MIN_CYC - `FMH_CNT_ONE) begin
                        if (!sleep_cmd) begin
                            sleep_request_n_ff <= 1'b1;
                            wake_ff <= 1'b1;
                            cnt_ff <= {`FMH_CNT_W{1'b0}};
                        end
                    end else begin
                        cnt_ff <= cnt_ff + `FMH_CNT_ONE;
                    end
                end else if (cnt_ff >= WAKE_W - `FMH_CNT_ONE) begin
                    // RQ14: all waits rounded up to cycles
                    asleep_ff <= 1'b0;
                    wake_ff <= 1'b0;
                    cnt_ff <= {`FMH_CNT_W{1'b0}};
                    state_ff <= ST_IDLE;
                end else begin
                    cnt_ff <= cnt_ff + `FMH_CNT_ONE;
                end
            end
            // Illegal code recovers through the power-up wait
            default: begin
                state_ff <= ST_PWRUP;
                cnt_ff <= {`FMH_CNT_W{1'b0}};
            end
        endcase
    end
end

endmodule

// file: src/fmh_defines.vh
// Timing and width constants for the nonvolatile SRAM-style memory host controller
`ifndef FMH_DEFINES_VH
`define FMH_DEFINES_VH
`define FMH_CLK_PS 4000
`define FMH_PU_NS 1000000
`define FMH_WAKE_NS 450000
`define FMH_COL_NS 15
`define FMH_ACC_NS 90
`define FMH_WP_NS 25
`define FMH_PC_NS 30
`define FMH_SLP_MIN_NS 1000
`define FMH_CYC(ns) (((ns) * 1000 + `FMH_CLK_PS - 1) / `FMH_CLK_PS)
`define FMH_ADDR_W 16
`define FMH_DATA_W 16
`define FMH_CNT_W 20
`define FMH_CNT_ONE 20'h00001
`endif

// file: testbench/fmh_host_asserts.sv
// Checker on the host pins of the memory sequencer
`timescale 1ns/1ps
module fmh_host_asserts #(
    parameter PU_CYC = 20,
    parameter WAKE_CYC = 10
) (
    input logic clk, arst_n, req_valid, req_ready, req_write, rsp_valid_ff,
    input logic [1:0] req_lane_n,
    input logic chip_select_n_ff, write_strobe_n_ff, output_gate_n_ff,
    input logic upper_lane_select_n_ff, lower_lane_select_n_ff, sleep_request_n_ff, data_lines_oe_ff,
    input logic [15:0] addr_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [19:0] cyc_ff;
    // Cycles since reset, saturating
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) cyc_ff <= 20'h00000;
        else if (cyc_ff < PU_CYC) cyc_ff <= cyc_ff + 20'h00001;
    end
    sequence take_s; req_valid && req_ready; endsequence
    pu_wait_a: assert property (cyc_ff < PU_CYC |-> chip_select_n_ff) else $error("early access");
    col_hold_a: assert property ($fell(chip_select_n_ff) |=> $stable(addr_ff) [*4]) else $error("column moved");
    wake_wait_a: assert property ($rose(sleep_request_n_ff) |-> chip_select_n_ff [*8]) else $error("early wake");
    lane_sel_a: assert property (take_s |=> {upper_lane_select_n_ff, lower_lane_select_n_ff} == $past(req_lane_n))
        else $error("lane mismatch");
    wr_data_a: assert property (!write_strobe_n_ff |-> data_lines_oe_ff) else $error("data not driven");
    no_fight_a: assert property (!output_gate_n_ff |-> !data_lines_oe_ff) else $error("bus contention");
    ready_a: assert property (req_ready |-> chip_select_n_ff && sleep_request_n_ff) else $error("bad ready");
    rd_time_a: assert property ((take_s and !req_write) |-> ##[20:30] rsp_valid_ff) else $error("late read");
endmodule
bind fmh_host fmh_host_asserts #(.PU_CYC(PU_CYC), .WAKE_CYC(WAKE_CYC)) chk_u (.*);

// file: testbench/fmh_mem_model.sv
// Behavioural word memory answering the host pins
`timescale 1ns/1ps
module fmh_mem_model (
    input logic cs_n, we_n, oe_n, upper_n, lower_n, sleep_n,
    input logic [15:0] addr, din,
    output logic [15:0] dout
);
    logic [15:0] mem [0:255];
    logic wr, rd;
    initial foreach (mem[i]) mem[i] = 16'h0000;
    // Sleep wins; write only while both strobes low
    assign wr = sleep_n && !cs_n && !we_n;
    assign rd = sleep_n && !cs_n && we_n && !oe_n;
    // Latch selected lanes on first strobe rise
    always @(negedge wr) begin
        if (!lower_n) mem[addr[7:0]][7:0] = din[7:0];
        if (!upper_n) mem[addr[7:0]][15:8] = din[15:8];
    end
    assign dout = {rd && !upper_n ? mem[addr[7:0]][15:8] : ~mem[addr[7:0]][15:8],
                   rd && !lower_n ? mem[addr[7:0]][7:0] : ~mem[addr[7:0]][7:0]};
endmodule

// file: testbench/tb_fmh_host.sv
// Self-checking bench for the memory host sequencer
`timescale 1ns/1ps
module tb_fmh_host;
    logic clk = 0, arst_n = 0, req_valid = 0, req_write = 0, sleep_cmd = 0;
    logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000;
    logic [1:0] req_lane_n = 2'b00;
    wire req_ready, rsp, asleep, cs_n, we_n, oe_n, upper_n, lower_n, sleep_n, oe;
    wire [15:0] rdata, addr, din, dout;
    int failures = 0, n_checks = 0, cyc = 0, n;
    fmh_host #(.PU_CYC(20), .WAKE_CYC(10)) dut_u (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_lane_n(req_lane_n), .sleep_cmd(sleep_cmd), .rsp_valid_ff(rsp), .rsp_rdata_ff(rdata),
        .asleep_ff(asleep), .chip_select_n_ff(cs_n), .write_strobe_n_ff(we_n), .output_gate_n_ff(oe_n),
        .upper_lane_select_n_ff(upper_n), .lower_lane_select_n_ff(lower_n), .sleep_request_n_ff(sleep_n),
        .addr_ff(addr), .data_lines_in(din), .data_lines_out_ff(dout), .data_lines_oe_ff(oe));
    fmh_mem_model mem_u (.cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .upper_n(upper_n), .lower_n(lower_n),
        .sleep_n(sleep_n),
        .addr(addr), .din(dout), .dout(din));
    initial forever #2 clk = ~clk;
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // One access, returns while the response pulse is high
    task acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [1:0] ln);
        req_valid = 1; req_write = w; req_addr = a; req_wdata = d; req_lane_n = ln;
        while (req_ready !== 1'b1) @(posedge clk) #1;
        @(posedge clk) #1 req_valid = 0;
        while (rsp !== 1'b1) @(posedge clk) #1;
    endtask
    task t_bytes;
        acc(1, 16'h0005, 16'h1234, 2'b00);
        acc(1, 16'h0005, 16'hAB99, 2'b01);
        acc(0, 16'h0005, 16'h0000, 2'b00); chk(rdata, 16'hAB34);
        acc(1, 16'h0006, 16'h77CD, 2'b10);
        acc(0, 16'h0006, 16'h0000, 2'b10); chk({8'h00, rdata[7:0]}, 16'h00CD);
        acc(0, 16'h0006, 16'h0000, 2'b00); chk(rdata, 16'h00CD);
        acc(0, 16'h0005, 16'h0000, 2'b01); chk({rdata[15:8], 8'h00}, 16'hAB00);
    endtask
    task t_sleep;
        acc(1, 16'h0009, 16'h5AA5, 2'b00);
        sleep_cmd = 1;
        while (asleep !== 1'b1) @(posedge clk) #1;
        chk({14'h0000, sleep_n, req_ready}, 16'h0000);
        repeat (260) @(posedge clk);
        #1 sleep_cmd = 0;
        while (sleep_n !== 1'b1) @(posedge clk) #1;
        n = 0;
        while (asleep === 1'b1) begin @(posedge clk) #1; n++; end
        chk(16'(n >= 10), 16'h0001);
        acc(0, 16'h0009, 16'h0000, 2'b00); chk(rdata, 16'h5AA5);
    endtask
    // Power-up wait: ready only after the full wait from reset release
    task t_pwrup;
        n = 0;
        while (req_ready !== 1'b1) begin @(posedge clk) #1; n++; end
        chk(16'(n), 16'h0014);
    endtask
    // Mid-run reset: pins idle at once, power-up wait repeats, contents kept
    task t_reset;
        arst_n = 0;
        repeat (3) @(posedge clk);
        #1 arst_n = 1;
        chk({9'h000, cs_n, we_n, oe_n, upper_n, lower_n, sleep_n, oe}, 16'h007E);
        t_pwrup;
        acc(0, 16'h0005, 16'h0000, 2'b00); chk(rdata, 16'hAB34);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            $display("[FAIL] %0t timeout", $time);
            test_done;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 arst_n = 1;
        chk({15'h0000, req_ready}, 16'h0000);
        t_pwrup;
        t_bytes;
        t_sleep;
        t_reset;
        test_done;
    end
endmodule
